/* File: usfb_cfg.svh */
// Purpose: Offsets, reset values and timing counts of the usfb serial core
// Assumes: Avalon-MM slave, one 32-bit word per byte register
// Notes: Byte address is four times the word index below
// Operation
// - Loopback joins transmit shifter to receive shifter.
// - Loopback forces nine data bits, no parity.
// - 7/8-bit frame: start, data, parity, stops.
// - Nine-bit frame: ninth bit from control, status.
// - Baud from prescaler then 11-bit divisor.
// - Prescaler codes divide in half steps.
// - Prescaler zero stops baud clock entirely.
// - Async rate is clock/(8*(P+1)*(N+1)), P the prescaler code.
// - Sync mode on the internal clock shifts at half the baud tick rate.
// - Tx interrupt: buffer empty and enabled.
// - Rx interrupt: buffer full and enabled.
// - Rx interrupt also: error and enabled.
// - Break request holds transmit line low.
// - Break: ten low bit times after bad stop.
// - No parity in loopback, attention, nine-bit.
// - Parity type picks odd, even, mark, space.
// - Receive and transmit buffers are byte registers.
// - Parity codes 00 odd, 01 even, 10 mark, 11 space.
// - Format codes 8, 7, 9, 9 with loopback.
// - Prescaler register holds select and divisor top.
// - Stop count 0 one stop, 1 two.
`ifndef USFB_CFG_SVH
`define USFB_CFG_SVH

// Word indexes of the registers
`define USFB_IX_RXBUF 3'h0
`define USFB_IX_TXBUF 3'h1
`define USFB_IX_PSR   3'h2
`define USFB_IX_BAUD  3'h3
`define USFB_IX_FRS   3'h4
`define USFB_IX_MDSL  3'h5
`define USFB_IX_STAT  3'h6
`define USFB_IX_ICTRL 3'h7

// Reset values
`define USFB_BYTE_RST  8'h00
`define USFB_ICTRL_RST 8'h01

// Field positions
`define USFB_PSC_LSB 3
`define USFB_EEI_BIT 7
`define USFB_ERI_BIT 6
`define USFB_ETI_BIT 5

// Timing counts
`define USFB_PSC_STEP 6'h02
`define USFB_OVS_LAST 4'hf
`define USFB_SMP_A    4'h7
`define USFB_SMP_B    4'h8
`define USFB_SMP_C    4'h9
`define USFB_BRK_BITS 4'ha

`endif

/* File: usfb_pkg.sv */
// Purpose: Types shared by the usfb serial core
// Assumes: Constants live in usfb_cfg.svh
// Notes: Structs match register bit layouts
package usfb_pkg;

	// Character format codes
	typedef enum logic [1:0] {
		USFB_CHR_8    = 2'b00,
		USFB_CHR_7    = 2'b01,
		USFB_CHR_9    = 2'b10,
		USFB_CHR_LOOP = 2'b11
	} usfb_chr_e;

	// Parity type codes
	typedef enum logic [1:0] {
		USFB_PAR_ODD   = 2'b00,
		USFB_PAR_EVEN  = 2'b01,
		USFB_PAR_MARK  = 2'b10,
		USFB_PAR_SPACE = 2'b11
	} usfb_par_e;

	// Receiver states
	typedef enum logic [1:0] {
		USFB_R_IDLE  = 2'b00,
		USFB_R_START = 2'b01,
		USFB_R_DATA  = 2'b10,
		USFB_R_BRK   = 2'b11
	} usfb_rx_e;

	// Frame select register layout
	typedef struct packed {
		logic      rsvd;
		logic      parity_enable;
		usfb_par_e parity_type;
		logic      tx_ninth_bit;
		logic      stop_count;
		usfb_chr_e char_format;
	} usfb_frs_s;

	// Mode select register layout
	typedef struct packed {
		logic [3:0] rsvd;
		logic       clk_ext;
		logic       line_break_request;
		logic       attn;
		logic       sync_mode;
	} usfb_mdsl_s;

endpackage

/* File: usfb_top.sv */
// Purpose: Serial core with frame formats, baud generator, break and irqs
// Assumes: Single clock, Avalon-MM slave with waitrequest
// Notes: Every access made with ce high answers at the second edge
`timescale 1ns/1ps
`default_nettype none
`include "usfb_cfg.svh"

module usfb_top (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic [2:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic             serial_tx_pin,
	input  wire logic        serial_rx_pin,
	input  wire logic        serial_clock_in,
	output logic             serial_clock_out,
	output logic             serial_clock_oe,
	output logic             tx_irq,
	output logic             rx_irq
);
	import usfb_pkg::*;

	// Software visible storage
	logic [7:0]  rx_data_buffer;       // Received byte
	logic [7:0]  tx_data_buffer;       // Byte waiting to send
	logic [7:0]  divisor_low_register; // Divisor bits 7..0
	logic [4:0]  prescaler_select;     // First stage code
	logic [2:0]  div_hi;               // Divisor bits 10..8
	usfb_frs_s   frs;                  // Frame settings
	usfb_mdsl_s  mdsl;                 // Mode settings
	logic        tx_buffer_empty;      // Buffer free
	logic        rx_buffer_full;       // Byte waiting
	logic        par_err;              // Parity error
	logic        frm_err;              // Framing error
	logic        ovr_err;              // Overrun error
	logic        brk_det;              // Break seen
	logic        brk_pend;             // Break clear requested
	logic        rx_ninth_bit;         // Last ninth bit
	logic        tx_irq_enable;        // Tx irq gate
	logic        rx_irq_enable;        // Rx irq gate
	logic        error_irq_enable;     // Error irq gate
	logic        ack_q;                // Access taken last edge

	// Bus decode
	logic        req;
	logic        act;
	logic        wr;
	logic        rd;
	logic        wr_rxbuf;
	logic        wr_txbuf;
	logic        wr_psr;
	logic        wr_baud;
	logic        wr_frs;
	logic        wr_mdsl;
	logic        wr_ictrl;
	logic        rd_rxbuf;
	logic        rd_stat;
	logic [7:0]  wbyte;
	logic [7:0]  rd_mux;

	assign req      = avs_read | avs_write;
	assign act      = ce & req & ~ack_q;
	assign wr       = act & avs_write & avs_byteenable[0];
	assign rd       = act & avs_read;
	assign wbyte    = avs_writedata[7:0];
	assign wr_rxbuf = wr & (avs_address == `USFB_IX_RXBUF);
	assign wr_txbuf = wr & (avs_address == `USFB_IX_TXBUF);
	assign wr_psr   = wr & (avs_address == `USFB_IX_PSR);
	assign wr_baud  = wr & (avs_address == `USFB_IX_BAUD);
	assign wr_frs   = wr & (avs_address == `USFB_IX_FRS);
	assign wr_mdsl  = wr & (avs_address == `USFB_IX_MDSL);
	assign wr_ictrl = wr & (avs_address == `USFB_IX_ICTRL);
	assign rd_rxbuf = rd & (avs_address == `USFB_IX_RXBUF);
	assign rd_stat  = rd & (avs_address == `USFB_IX_STAT);
	// Wait one cycle, answer at the second edge
	assign avs_waitrequest = req & ~ack_q;

	// Format decode
	logic        nine;      // Nine data bits
	logic        loop;      // Internal loopback
	logic        pon;       // Parity in use
	logic [3:0]  nd;        // Data bit count
	logic [3:0]  need;      // Data plus parity bits
	logic [3:0]  tx_len;    // Whole frame length
	logic        rx_err;    // Error summary
	logic        tx_busy;   // Transmit in progress

	assign nine = frs.char_format[1];
	assign loop = (frs.char_format == USFB_CHR_LOOP);
	assign nd   = (frs.char_format == USFB_CHR_7) ? 4'h7 : (nine ? 4'h9 : 4'h8);
	assign pon  = frs.parity_enable & ~nine & ~mdsl.attn;
	assign need = 4'(nd + {3'h0, pon});
	assign tx_len = 4'(4'h2 + nd + {3'h0, pon} + {3'h0, frs.stop_count});
	assign rx_err = par_err | frm_err | ovr_err;

	function automatic logic par_bit(input logic [8:0] d, input usfb_par_e t);
		logic p;
		p = 1'b0;
		unique case (t)
			USFB_PAR_ODD:   p = ~^d;
			USFB_PAR_EVEN:  p = ^d;
			USFB_PAR_MARK:  p = 1'b0;
			USFB_PAR_SPACE: p = 1'b1;
		endcase
		return p;
	endfunction

	// start, data LSB first, parity, stops
	function automatic logic [11:0] build(input logic [8:0] d, input logic [3:0] n,
		input logic p, input logic en);
		logic [11:0] f;
		f = 12'hfff;
		f[0] = 1'b0;
		for (int i = 0; i < 9; i++)
		begin
			if (i < int'(n))
				f[i + 1] = d[i];
		end
		if (en)
			f[4'(n + 4'h1)] = p;
		return f;
	endfunction

	// Baud generator
	logic        clk_on;    // Prescaler not zero
	logic        restart;   // Rate rewritten
	logic [5:0]  psc_acc;   // Half-step accumulator
	logic [5:0]  psc_sum;
	logic [5:0]  psc_lim;
	logic        psc_tick;  // First stage output
	logic [10:0] div_cnt;   // Second stage count
	logic        tick;      // Baud clock tick

	assign clk_on   = (prescaler_select != 5'h00);
	assign restart  = wr_psr | wr_baud;
	assign psc_sum  = 6'(psc_acc + `USFB_PSC_STEP);
	assign psc_lim  = 6'({1'b0, prescaler_select} + 6'h01);
	// tick when half-steps reach code plus one
	assign psc_tick = clk_on & (psc_sum >= psc_lim);
	// second stage counts divisor plus one
	assign tick     = psc_tick & (div_cnt == {div_hi, divisor_low_register});

	// First stage accumulator
	always_ff @(posedge clk)
	begin
		if (!rstn || restart)
			psc_acc <= 6'h00;
		else if (ce && clk_on)
			psc_acc <= psc_tick ? 6'(psc_sum - psc_lim) : psc_sum;
	end

	// Second stage counter
	always_ff @(posedge clk)
	begin
		if (!rstn || restart)
			div_cnt <= 11'h000;
		else if (ce && psc_tick)
			div_cnt <= tick ? 11'h000 : 11'(div_cnt + 11'h001);
	end

	// Synchronous clock and pin synchronisers
	logic        sck_q;     // Internal shift clock
	logic        sck_prev;  // Last shift clock level
	logic        sck_lvl;   // Selected shift clock
	logic        ck_s1;
	logic        ck_s2;
	logic        rx_s1;
	logic        rx_s2;
	logic        rise_evt;
	logic        fall_evt;

	// Two flops on each pin input
	always_ff @(posedge clk)
	begin
		if (!rstn)
			{ck_s1, ck_s2, rx_s1, rx_s2} <= 4'hf;
		else if (ce)
			{ck_s1, ck_s2, rx_s1, rx_s2} <= {serial_clock_in, ck_s1, serial_rx_pin, rx_s1};
	end

	// one clock edge per tick in sync mode on the internal clock, two edges per bit
	always_ff @(posedge clk)
	begin
		if (!rstn)
			{sck_q, sck_prev} <= 2'h3;
		else if (ce)
		begin
			sck_prev <= sck_lvl;
			if (!mdsl.sync_mode || mdsl.clk_ext)
				sck_q <= 1'b1;
			else if (tick)
				sck_q <= ~sck_q;
		end
	end

	assign sck_lvl  = mdsl.clk_ext ? ck_s2 : sck_q;
	// no shift edges while the clock is stopped
	assign rise_evt = clk_on & mdsl.sync_mode & sck_lvl & ~sck_prev;
	assign fall_evt = clk_on & mdsl.sync_mode & ~sck_lvl & sck_prev;
	assign serial_clock_out = sck_q;
	assign serial_clock_oe  = mdsl.sync_mode & ~mdsl.clk_ext;

	// Transmitter
	logic [11:0] tx_sh;     // Frame shifter
	logic [3:0]  tx_cnt;    // Bits left
	logic [3:0]  tx_ovs;    // Oversample phase
	logic        tx_adv;    // Next bit now
	logic        tx_line;   // Internal line level
	logic [8:0]  tx_d;      // Data with ninth bit

	// ninth bit from control, full byte data
	assign tx_d    = nine ? {frs.tx_ninth_bit, tx_data_buffer} :
		(frs.char_format == USFB_CHR_7) ? {2'h0, tx_data_buffer[6:0]} : {1'b0, tx_data_buffer};
	// sixteen ticks per bit when async
	assign tx_adv  = mdsl.sync_mode ? rise_evt : (tick & (tx_ovs == `USFB_OVS_LAST));
	assign tx_line = ~mdsl.line_break_request & tx_sh[0];
	assign tx_busy = (tx_cnt != 4'h0);

	// Transmit oversample phase
	always_ff @(posedge clk)
	begin
		if (!rstn)
			tx_ovs <= 4'h0;
		else if (ce && tick)
			tx_ovs <= 4'(tx_ovs + 4'h1);
	end

	// Shift, reload from buffer, buffer empty flag
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			tx_sh           <= 12'hfff;
			tx_cnt          <= 4'h0;
			tx_buffer_empty <= 1'b1;
		end
		else if (ce)
		begin
			if (tx_adv && tx_cnt > 4'h1)
			begin
				tx_sh  <= {1'b1, tx_sh[11:1]};
				tx_cnt <= 4'(tx_cnt - 4'h1);
			end
			else if (tx_adv && !tx_buffer_empty)
			begin
				tx_sh           <= build(tx_d, nd, par_bit(tx_d, frs.parity_type), pon);
				tx_cnt          <= tx_len;
				tx_buffer_empty <= 1'b1;
			end
			else if (tx_adv)
			begin
				tx_sh  <= 12'hfff;
				tx_cnt <= 4'h0;
			end
			// New byte written wins over the reload
			if (wr_txbuf)
				tx_buffer_empty <= 1'b0;
		end
	end

	// Registered pin, idle high in loopback
	always_ff @(posedge clk)
	begin
		if (!rstn)
			serial_tx_pin <= 1'b1;
		else if (ce)
			serial_tx_pin <= loop ? 1'b1 : tx_line;
	end

	// Receiver
	usfb_rx_e    rx_st;     // Receiver state
	logic [3:0]  rx_ovs;    // Oversample phase
	logic        rx_sa;     // First sample
	logic        rx_sb;     // Second sample
	logic [3:0]  rx_cnt;    // Bits collected
	logic [8:0]  rx_sh;     // Collected bits
	logic [3:0]  brk_cnt;   // Low bit times
	logic        rx_line;   // Selected input
	logic        maj;       // Vote of three
	logic        stb;       // Bit decided
	logic        v;         // Bit value
	logic        done;      // Stop bit decided
	logic        ign;       // Data char in attention
	logic        brk_hit;   // Tenth low bit time
	logic [7:0]  rx_d;      // Received data byte
	logic [8:0]  rx_pd;     // Data for parity check

	// loopback feeds the transmitter into the receiver
	assign rx_line = loop ? tx_line : rx_s2;
	assign maj     = (rx_sa & rx_sb) | (rx_sa & rx_line) | (rx_sb & rx_line);
	assign stb     = mdsl.sync_mode ? fall_evt :
		(tick & (rx_ovs == `USFB_SMP_C) & (rx_st != USFB_R_IDLE));
	assign v       = mdsl.sync_mode ? rx_line : maj;
	assign done    = (rx_st == USFB_R_DATA) & stb & (rx_cnt == need);
	assign ign     = mdsl.attn & ~rx_sh[8];
	// ten low bit times after a bad stop
	assign brk_hit = (rx_st == USFB_R_BRK) & stb & ~v & (brk_cnt == 4'(`USFB_BRK_BITS - 4'h1));
	assign rx_d    = (frs.char_format == USFB_CHR_7) ? {1'b0, rx_sh[6:0]} : rx_sh[7:0];
	assign rx_pd   = {1'b0, rx_d};

	// Receive sampling and frame walk
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			rx_st   <= USFB_R_IDLE;
			rx_ovs  <= 4'h0;
			{rx_sa, rx_sb} <= 2'h3;
			rx_cnt  <= 4'h0;
			rx_sh   <= 9'h000;
			brk_cnt <= 4'h0;
		end
		else if (ce)
		begin
			if (tick)
				rx_ovs <= 4'(rx_ovs + 4'h1);
			if (tick && rx_ovs == `USFB_SMP_A)
				rx_sa <= rx_line;
			if (tick && rx_ovs == `USFB_SMP_B)
				rx_sb <= rx_line;
			unique case (rx_st)
				// Wait for a start bit
				USFB_R_IDLE:
				begin
					rx_cnt <= 4'h0;
					if (mdsl.sync_mode)
					begin
						if (stb && !v)
							rx_st <= USFB_R_DATA;
					end
					else if (!rx_line && clk_on)
					begin
						rx_st  <= USFB_R_START;
						rx_ovs <= 4'h0;
					end
				end
				// Confirm start bit low
				USFB_R_START:
					if (stb)
						rx_st <= v ? USFB_R_IDLE : USFB_R_DATA;
				// Collect data and parity, then stop
				USFB_R_DATA:
					if (stb)
					begin
						if (rx_cnt < need)
						begin
							rx_sh[rx_cnt] <= v;
							rx_cnt        <= 4'(rx_cnt + 4'h1);
						end
						else
						begin
							rx_st   <= v ? USFB_R_IDLE : USFB_R_BRK;
							brk_cnt <= 4'h0;
						end
					end
				// Count low bit times after a bad stop
				USFB_R_BRK:
					if (stb)
					begin
						if (v)
							rx_st <= USFB_R_IDLE;
						else if (brk_cnt != `USFB_BRK_BITS)
							brk_cnt <= 4'(brk_cnt + 4'h1);
					end
			endcase
		end
	end

	// Receive buffer and status flags, set wins over clear
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			rx_data_buffer <= `USFB_BYTE_RST;
			rx_buffer_full <= 1'b0;
			{par_err, frm_err, ovr_err, brk_det, brk_pend, rx_ninth_bit} <= 6'h00;
		end
		else if (ce)
		begin
			// Read side effects
			if (rd_rxbuf)
				rx_buffer_full <= 1'b0;
			if (rd_stat)
				{par_err, frm_err, ovr_err} <= 3'h0;
			if (rd_stat && rx_line)
				brk_det <= 1'b0;
			else if (rd_stat)
				brk_pend <= 1'b1;
			if (brk_pend && rx_line)
			begin
				brk_det  <= 1'b0;
				brk_pend <= 1'b0;
			end
			if (wr_rxbuf)
				rx_data_buffer <= wbyte;
			if (done && !ign)
			begin
				rx_data_buffer <= rx_d;
				rx_ninth_bit   <= rx_sh[8];
				rx_buffer_full <= 1'b1;
				if (rx_buffer_full)
					ovr_err <= 1'b1;
				// parity checked only when in use
				if (pon && rx_sh[nd] != par_bit(rx_pd, frs.parity_type))
					par_err <= 1'b1;
				if (!v)
					frm_err <= 1'b1;
			end
			if (brk_hit)
				brk_det <= 1'b1;
		end
	end

	// Control registers
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			tx_data_buffer       <= `USFB_BYTE_RST;
			divisor_low_register <= `USFB_BYTE_RST;
			{prescaler_select, div_hi} <= `USFB_BYTE_RST;
			frs  <= usfb_frs_s'(`USFB_BYTE_RST);
			mdsl <= usfb_mdsl_s'(`USFB_BYTE_RST);
			{tx_irq_enable, rx_irq_enable, error_irq_enable} <= 3'h0;
		end
		else if (ce)
		begin
			if (wr_txbuf)
				tx_data_buffer <= wbyte;
			// select and divisor top share a byte
			if (wr_psr)
				{prescaler_select, div_hi} <= wbyte;
			if (wr_baud)
				divisor_low_register <= wbyte;
			if (wr_frs)
				frs <= usfb_frs_s'({1'b0, wbyte[6:0]});
			if (wr_mdsl)
				mdsl <= usfb_mdsl_s'({4'h0, wbyte[3:0]});
			// Address character ends attention
			if (done && mdsl.attn && rx_sh[8])
				mdsl.attn <= 1'b0;
			if (wr_ictrl)
			begin
				tx_irq_enable    <= wbyte[`USFB_ETI_BIT];
				rx_irq_enable    <= wbyte[`USFB_ERI_BIT];
				error_irq_enable <= wbyte[`USFB_EEI_BIT];
			end
		end
	end

	// Read data selection
	assign rd_mux =
		(avs_address == `USFB_IX_RXBUF) ? rx_data_buffer :
		(avs_address == `USFB_IX_TXBUF) ? tx_data_buffer :
		(avs_address == `USFB_IX_PSR)   ? {prescaler_select, div_hi} :
		(avs_address == `USFB_IX_BAUD)  ? divisor_low_register :
		(avs_address == `USFB_IX_FRS)   ? frs :
		(avs_address == `USFB_IX_MDSL)  ? mdsl :
		(avs_address == `USFB_IX_STAT)  ?
			{1'b0, tx_busy, rx_ninth_bit, brk_det, rx_err, ovr_err, frm_err, par_err} :
		{error_irq_enable, rx_irq_enable, tx_irq_enable, 3'h0, rx_buffer_full, tx_buffer_empty};

	// Access handshake and read data latch
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			ack_q        <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= act;
			if (rd)
				avs_readdata <= {24'h00_0000, rd_mux};
		end
	end

	assign tx_irq = tx_buffer_empty & tx_irq_enable;
	assign rx_irq = (rx_buffer_full & rx_irq_enable) | (rx_err & error_irq_enable);

endmodule
`default_nettype wire

/* File: usfb_top_assertions.sv */
// Purpose: Port-level checks for usfb_top
// Assumes: Shadow bytes follow every write the core takes
// Notes: Bound to each usfb_top instance
`timescale 1ns/1ps
`default_nettype none
`include "usfb_cfg.svh"

module usfb_top_assertions (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        ce,
	input wire logic [2:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        serial_tx_pin,
	input wire logic        serial_rx_pin,
	input wire logic        serial_clock_in,
	input wire logic        serial_clock_out,
	input wire logic        serial_clock_oe,
	input wire logic        tx_irq,
	input wire logic        rx_irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	logic [7:0] psr_q;  // Shadow prescaler byte
	logic [7:0] frs_q;  // Shadow frame byte
	logic [7:0] mdsl_q; // Shadow mode byte
	logic [7:0] ictl_q; // Shadow irq byte
	wire wr_tk = avs_write && avs_waitrequest && ce && avs_byteenable[0]; // Write taken
	wire req = (avs_read || avs_write) && ce;             // Live request
	wire brk_on = mdsl_q[2] && frs_q[1:0] != 2'b11;       // Break on real pin
	wire lp_on = frs_q[1:0] == 2'b11;                     // Loopback format
	wire quiet = psr_q[7:3] == 5'h00 && !avs_write;       // Clock stopped
	wire tx_wr = wr_tk && avs_address == `USFB_IX_TXBUF;  // Buffer load

	// Track control bytes as the core takes them
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			psr_q  <= 8'h00;
			frs_q  <= 8'h00;
			mdsl_q <= 8'h00;
			ictl_q <= 8'h00;
		end
		else if (wr_tk)
		begin
			if (avs_address == `USFB_IX_PSR)
				psr_q <= avs_writedata[7:0];
			if (avs_address == `USFB_IX_FRS)
				frs_q <= avs_writedata[7:0];
			if (avs_address == `USFB_IX_MDSL)
				mdsl_q <= avs_writedata[7:0];
			if (avs_address == `USFB_IX_ICTRL)
				ictl_q <= avs_writedata[7:0];
		end
	end

	sequence s_brk_held;
		brk_on [*4];
	endsequence
	sequence s_loop_held;
		lp_on [*4];
	endsequence
	sequence s_stopped;
		quiet [*4];
	endsequence

	a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("Request answered with no wait cycle");
	a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("Request not answered after one wait");
	a_idle_free: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("Wait raised with no request");
	a_upper_zero: assert property (avs_readdata[31:8] == 24'h00_0000)
		else $error("Read data above the byte not zero");
	a_tx_mask: assert property (!ictl_q[`USFB_ETI_BIT] |-> !tx_irq)
		else $error("Transmit irq while disabled");
	a_rx_mask: assert property (!ictl_q[`USFB_ERI_BIT] && !ictl_q[`USFB_EEI_BIT] |-> !rx_irq)
		else $error("Receive irq while disabled");
	a_tx_clear: assert property (tx_wr |=> !tx_irq)
		else $error("Transmit irq kept after buffer load");
	a_sck_drive: assert property (serial_clock_oe == (mdsl_q[0] && !mdsl_q[3]))
		else $error("Clock pin drive wrong for mode");
	a_brk_low: assert property (s_brk_held |-> !serial_tx_pin)
		else $error("Transmit pin high during break");
	a_loop_high: assert property (s_loop_held |-> serial_tx_pin)
		else $error("Transmit pin moved in loopback");
	a_psc_stop: assert property (s_stopped |-> $stable(serial_tx_pin))
		else $error("Transmit pin moved with clock stopped");
endmodule

bind usfb_top usfb_top_assertions u_usfb_top_assertions (
	.clk, .rstn, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_byteenable, .avs_readdata, .avs_waitrequest, .serial_tx_pin,
	.serial_rx_pin, .serial_clock_in, .serial_clock_out, .serial_clock_oe,
	.tx_irq, .rx_irq
);
`default_nettype wire

/* File: usfb_remote.sv */
// Purpose: Remote serial device facing the usfb core
// Assumes: Asynchronous framing, bit length given in clocks
// Notes: Line rests high between frames
`timescale 1ns/1ps
`default_nettype none

module usfb_remote (
	input  wire logic clk,     // System clock
	input  wire logic tx_line, // Line from the core
	output var  logic rx_line  // Line into the core
);
	// Idle level at start
	initial
		rx_line = 1'b1;

	// Drive n bits LSB first, 16 clocks each
	task automatic send(input logic [31:0] v, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			rx_line <= v[i];
			repeat (15) @(posedge clk);
		end
	endtask

	// Find a start bit, then sample n bits at mid-bit
	task automatic grab(input int n, input int p, output logic [11:0] q);
		q = 12'h000;
		@(posedge clk);
		while (tx_line !== 1'b0)
			@(posedge clk);
		repeat (p / 2) @(posedge clk);
		for (int i = 0; i < n; i++)
		begin
			repeat (p) @(posedge clk);
			q[i] = tx_line;
		end
	endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for usfb_top
// Assumes: Prescaler code 1, divisor 0: one tick per clock
// Notes: A bit lasts 16 clocks at that rate
`timescale 1ns/1ps
`default_nettype none
`include "usfb_cfg.svh"

module testbench;
	logic        clk;      // System clock
	logic        rstn;     // Reset, active low
	logic [2:0]  adr;      // Bus word index
	logic        rd_s;     // Bus read
	logic        wr_s;     // Bus write
	logic [31:0] wd;       // Bus write data
	logic [3:0]  be;       // Bus byte lanes
	logic [31:0] rdata;    // Bus read data
	logic        wait_s;   // Bus stall
	logic        tx_pin;   // Serial out
	logic        rx_pin;   // Serial in
	logic        tx_irq;   // Transmit irq
	logic        rx_irq;   // Receive irq
	logic        sck_in;   // External shift clock
	logic        sck_out;  // Internal shift clock
	int          failures; // Mismatches
	int          n_checks; // Comparisons
	int          cycles;   // Timeout count
	logic [7:0]  q;        // Last read byte
	logic [11:0] f;        // Captured frame
	// Rows: {byte enable, write, index, data, expected read}
	localparam logic [20:0] rows [19] = '{
		21'h00_0000, 21'h01_0000, 21'h02_0000, 21'h03_0000, 21'h04_0000,
		21'h05_0000, 21'h06_0000, 21'h07_0001, 21'h1A_0800, 21'h02_0008,
		21'h1B_A500, 21'h03_00A5, 21'h1B_0000, 21'h0C_FF00, 21'h04_0000,
		21'h1E_FF00, 21'h06_0000, 21'h1F_FF00, 21'h07_00E1
	};

	usfb_top u_usfb_top (
		.clk(clk), .rstn(rstn), .ce(1'b1), .avs_address(adr), .avs_read(rd_s),
		.avs_write(wr_s), .avs_writedata(wd), .avs_byteenable(be),
		.avs_readdata(rdata), .avs_waitrequest(wait_s), .serial_tx_pin(tx_pin),
		.serial_rx_pin(rx_pin), .serial_clock_in(sck_in), .serial_clock_out(sck_out),
		.serial_clock_oe(), .tx_irq(tx_irq), .rx_irq(rx_irq)
	);
	usfb_remote u_usfb_remote (.clk(clk), .tx_line(tx_pin), .rx_line(rx_pin));

	// Free-running clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			failures++;
			report_and_stop();
		end
	end

	// Compare one value and count it
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One bus access, held until the wait drops
	task automatic bus(input logic w, input logic b, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		adr  <= a;
		wr_s <= w;
		rd_s <= !w;
		be   <= {3'b000, b};
		wd   <= {24'h00_0000, d};
		@(posedge clk);
		while (wait_s !== 1'b0)
			@(posedge clk);
		q = rdata[7:0];
		rd_s <= 1'b0;
		wr_s <= 1'b0;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		bus(1'b1, 1'b1, a, d);
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		bus(1'b0, 1'b1, a, 8'h00);
		chk(q, e);
	endtask

	// Bounded wait for the receive irq
	task automatic wait_rx;
		int n;
		n = 0;
		while (rx_irq !== 1'b1 && n < 2000)
		begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic report_and_stop;
		$display("Checks %0d, failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		rstn = 1'b0;
		adr = 3'h0;
		rd_s = 1'b0;
		wr_s = 1'b0;
		wd = 32'h0000_0000;
		be = 4'h0;
		sck_in = 1'b1;
		failures = 0;
		n_checks = 0;
		cycles = 0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 19; i++)
		begin
			bus(rows[i][19], rows[i][20], rows[i][18:16], rows[i][15:8]);
			if (!rows[i][19])
				chk(q, rows[i][7:0]);
		end
		wr(`USFB_IX_ICTRL, 8'h20);
		chk(tx_irq, 1'b1);
		$display("Registers done");
		for (int p = 0; p < 4; p++)
		begin
			wr(`USFB_IX_FRS, {2'b01, p[1:0], 4'h5});
			wr(`USFB_IX_TXBUF, 8'h35);
			chk(tx_irq, 1'b0);
			u_usfb_remote.grab(10, 16, f);
			chk(f, {2'b00, 2'b11, p == 0 || p == 3, 7'h35});
		end
		wr(`USFB_IX_FRS, 8'h5A);
		wr(`USFB_IX_TXBUF, 8'hC3);
		u_usfb_remote.grab(11, 16, f);
		chk(f, 12'h7C3);
		$display("Transmit done");
		wr(`USFB_IX_FRS, 8'h00);
		wr(`USFB_IX_ICTRL, 8'h40);
		chk(tx_irq, 1'b0);
		u_usfb_remote.send(32'h0000_032C, 10);
		wait_rx();
		chk(rx_irq, 1'b1);
		rd(`USFB_IX_RXBUF, 8'h96);
		chk(rx_irq, 1'b0);
		wr(`USFB_IX_ICTRL, 8'h80);
		u_usfb_remote.send(32'h0000_04AA, 11);
		wait_rx();
		chk(rx_irq, 1'b1);
		rd(`USFB_IX_STAT, 8'h0A);
		@(posedge clk);
		chk(rx_irq, 1'b0);
		rd(`USFB_IX_RXBUF, 8'h55);
		u_usfb_remote.send(32'h0000_0000, 24);
		rd(`USFB_IX_STAT, 8'h1A);
		u_usfb_remote.send(32'h0000_0001, 1);
		rd(`USFB_IX_STAT, 8'h00);
		rd(`USFB_IX_RXBUF, 8'h00);
		// Odd parity on, zero byte sent with a wrong parity bit
		wr(`USFB_IX_FRS, 8'h40);
		u_usfb_remote.send(32'h0000_0400, 11);
		rd(`USFB_IX_STAT, 8'h09);
		rd(`USFB_IX_RXBUF, 8'h00);
		$display("Receive done");
		wr(`USFB_IX_MDSL, 8'h04);
		repeat (20) @(posedge clk);
		chk(tx_pin, 1'b0);
		wr(`USFB_IX_MDSL, 8'h00);
		repeat (3) @(posedge clk);
		chk(tx_pin, 1'b1);
		$display("Break done");
		wr(`USFB_IX_FRS, 8'h4B);
		wr(`USFB_IX_ICTRL, 8'h40);
		wr(`USFB_IX_TXBUF, 8'h6E);
		wait_rx();
		chk(tx_pin, 1'b1);
		rd(`USFB_IX_RXBUF, 8'h6E);
		bus(1'b0, 1'b1, `USFB_IX_STAT, 8'h00);
		chk(q & 8'h20, 8'h20);
		$display("Loopback done");
		wr(`USFB_IX_FRS, 8'h00);
		// Stop the clock before a new rate
		wr(`USFB_IX_PSR, 8'h00);
		wr(`USFB_IX_TXBUF, 8'h55);
		repeat (100) @(posedge clk);
		chk(tx_pin, 1'b1);
		wr(`USFB_IX_PSR, 8'h10);
		u_usfb_remote.grab(9, 24, f);
		chk(f, 12'h155);
		$display("Baud done");
		// Sync loopback on an external clock, prescaler kept on
		wr(`USFB_IX_FRS, 8'h03);
		wr(`USFB_IX_MDSL, 8'h09);
		wr(`USFB_IX_TXBUF, 8'hA7);
		repeat (30) @(posedge clk) sck_in <= ~sck_in;
		rd(`USFB_IX_RXBUF, 8'hA7);
		chk(sck_out, 1'b1);
		$display("Sync done");
		report_and_stop();
	end
endmodule
`default_nettype wire
